/* pcm_framer.sv */
// Behavioural framer: drives strobes, bit clock and serial data lines.
// Assumes one send call at a time, entered at a falling master edge.
module pcm_framer
(
  input  wire logic [1:0] dout_i,
  input  wire logic       clock_i,
  output logic            bclk_o,
  output logic [3:0]      stb_o,
  output logic [1:0]      din_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  int last [4] = '{default: -100000};
  initial {bclk_o, stb_o, din_o} = '0;
  // Cycle count used to space each strobe one frame apart.
  always @(posedge clock_i) cyc <= cyc + 1;
  // Burst of nb bits, MSB first; bit clock idles low so no stray edge.
  task automatic send(input int l, input int ch, input int nb, input int half,
                      input logic [15:0] w, output logic [15:0] got);
    int k;
    k = 2 * l + ch;
    got = '0;
    while (cyc - last[k] < pcm_port_pkg::FRAME_CYCLES) @(negedge clock_i);
    last[k] = cyc;
    stb_o[k] = 1'b1;
    repeat (4) @(negedge clock_i);
    for (int i = nb - 1; i >= 0; i--)
    begin
      din_o[l] = w[i];
      repeat (half) @(negedge clock_i);
      bclk_o = 1'b1;
      got = {got[14:0], dout_i[l]};
      repeat (half) @(negedge clock_i);
      bclk_o = 1'b0;
    end
    repeat (2) @(negedge clock_i);
    stb_o[k] = 1'b0;
    din_o[l] = ~din_o[l]; // A released line must not keep a stale bit.
    repeat (2) @(negedge clock_i);
  endtask : send
endmodule : pcm_framer

/* pcm_port_asserts.sv */
// Checker for the serial PCM port: timing relations at the top ports.
// Assumes one master clock; bound onto every pcm_serial_port.
module pcm_port_asserts
(
  input wire logic                    clock_i,
  input wire logic                    arst_n_i,
  input wire logic                    power_down_n_i,
  input wire logic                    strobed_serial_mode_i,
  input wire logic                    rx_side_strobe_a_i,
  input wire logic                    rx_side_strobe_b_i,
  input wire logic                    tx_side_strobe_a_i,
  input wire logic                    tx_side_strobe_b_i,
  input wire pcm_port_pkg::pcm_word_t ref_a_o,
  input wire logic [1:0]              rx_bus_mode_o,
  input wire logic                    send_out_o,
  input wire logic                    send_out_oe_o,
  input wire logic                    rx_out_o,
  input wire logic                    rx_out_oe_o,
  input wire logic                    standby_o
);
  // Power-down checks keep running while it is low; the others pause then.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i || !power_down_n_i);
  property p_stby; disable iff (!arst_n_i) standby_o == !power_down_n_i; endproperty
  a_stby: assert property (p_stby) else $error("standby wrong");
  property p_pdq; disable iff (!arst_n_i)
    !power_down_n_i |-> !send_out_oe_o && !rx_out_oe_o && !ref_a_o.valid; endproperty
  a_pdq: assert property (p_pdq) else $error("active in power down");
  property p_sidle;
    (!rx_side_strobe_a_i && !rx_side_strobe_b_i) [*4] |-> !send_out_oe_o && !send_out_o;
  endproperty
  a_sidle: assert property (p_sidle) else $error("send out driven idle");
  property p_ridle;
    (!tx_side_strobe_a_i && !tx_side_strobe_b_i) [*4] |-> !rx_out_oe_o && !rx_out_o;
  endproperty
  a_ridle: assert property (p_ridle) else $error("rx out driven idle");
  property p_scause;
    $rose(send_out_oe_o) |-> $past(rx_side_strobe_a_i, 3) || $past(rx_side_strobe_b_i, 3);
  endproperty
  a_scause: assert property (p_scause) else $error("send out without strobe");
  property p_rcause;
    $rose(rx_out_oe_o) |-> $past(tx_side_strobe_a_i, 3) || $past(tx_side_strobe_b_i, 3);
  endproperty
  a_rcause: assert property (p_rcause) else $error("rx out without strobe");
  property p_pulse; ref_a_o.valid |=> !ref_a_o.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_hold; strobed_serial_mode_i [*3] |=> $stable(rx_bus_mode_o); endproperty
  a_hold: assert property (p_hold) else $error("bus mode moved");
  c_ref: cover property (ref_a_o.valid);
  c_rout: cover property (rx_out_oe_o);
  c_mode: cover property (rx_bus_mode_o == 2'h3);
endmodule : pcm_port_asserts

bind pcm_serial_port pcm_port_asserts pcm_port_asserts_inst (.clock_i, .arst_n_i,
  .power_down_n_i, .strobed_serial_mode_i, .rx_side_strobe_a_i, .rx_side_strobe_b_i,
  .tx_side_strobe_a_i, .tx_side_strobe_b_i, .ref_a_o, .rx_bus_mode_o, .send_out_o,
  .send_out_oe_o, .rx_out_o, .rx_out_oe_o, .standby_o);

/* pcm_port_pkg.sv */
// Package for the serial PCM port front end: modes, widths and timing counts.
// Assumes a single 20 MHz master clock and no software-visible registers.
package pcm_port_pkg;

  // ---------------------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned CNT_W          = 5;
  localparam logic [4:0]  NARROW_BITS    = 5'h08;
  localparam logic [4:0]  WIDE_BITS      = 5'h10;
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned FRAME_NS       = 125000;
  localparam int unsigned FRAME_CYCLES   = FRAME_NS / (1000000000 / CLK_HZ);
  localparam int unsigned MIN_RATE_KBPS  = 128;
  localparam int unsigned MAX_RATE_KBPS  = 4096;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic {MODE_FRAMED, MODE_STROBED} port_mode_t;

  typedef struct packed {
    logic               valid;
    logic               wide;
    logic [WORD_W-1:0]  data;
  } pcm_word_t;

  typedef struct packed {
    logic a;
    logic b;
  } strobe_pair_t;

endpackage : pcm_port_pkg

/* pcm_serial_port.sv */
// Serial PCM port front end for two time-multiplexed canceller channels.
// Assumes a bit clock on a pin, oversampled by the master clock; the
// framer drives strobes and data, the device drives only the output lines.

// -----------------------------------------------------------------------------
// Lane: one serial line with two strobed channels.
// -----------------------------------------------------------------------------
module pcm_lane
(
  input  wire logic                            clock_i,
  input  wire logic                            arst_n_i,
  input  wire logic                            bclk_rise_i,
  input  wire logic                            bclk_fall_i,
  input  wire logic                            strobed_i,
  input  wire pcm_port_pkg::strobe_pair_t      strobe_i,
  input  wire logic                            din_i,
  input  wire logic [pcm_port_pkg::WORD_W-1:0] out_a_i,
  input  wire logic [pcm_port_pkg::WORD_W-1:0] out_b_i,
  output pcm_port_pkg::pcm_word_t              word_a_o,
  output pcm_port_pkg::pcm_word_t              word_b_o,
  output logic                                 dout_o,
  output logic                                 dout_oe_o
);
  logic [pcm_port_pkg::WORD_W-1:0] sh_ff, nxt_sh;
  logic [pcm_port_pkg::WORD_W-1:0] tx_ff, nxt_tx;
  logic [pcm_port_pkg::CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic                            chb_ff, nxt_chb;
  logic                            act_ff;
  logic                            oe_ff, nxt_oe;
  pcm_port_pkg::pcm_word_t         wa_ff, nxt_wa, wb_ff, nxt_wb;
  logic                            act;

  // Only the strobed mode moves data; a strobe that is low moves nothing.
  assign act = strobed_i && (strobe_i.a || strobe_i.b);

  // Shift on bit clock edges while a strobe is high; close the word when it drops.
  always_comb
  begin
    nxt_sh  = sh_ff;
    nxt_tx  = tx_ff;
    nxt_cnt = cnt_ff;
    nxt_chb = chb_ff;
    nxt_oe  = act;
    nxt_wa  = wa_ff;
    nxt_wb  = wb_ff;
    nxt_wa.valid = 1'b0;
    nxt_wb.valid = 1'b0;
    // Clearing at burst start keeps an 8-bit word free of the other channel's bits.
    if (act && !act_ff)
    begin
      nxt_sh  = '0;
      nxt_cnt = '0;
      nxt_chb = strobe_i.b;
      nxt_tx  = strobe_i.b ? out_b_i : out_a_i;
    end
    else if (act && bclk_fall_i && cnt_ff != '0)
      nxt_tx = {tx_ff[pcm_port_pkg::WORD_W-2:0], 1'b0};
    // The count saturates, so an overlong burst never wraps back to a legal length.
    if (act && bclk_rise_i)
    begin
      nxt_sh  = {nxt_sh[pcm_port_pkg::WORD_W-2:0], din_i};
      if (nxt_cnt != 5'h1f)
        nxt_cnt = nxt_cnt + 5'h01;
    end
    // A burst of exactly 8 or 16 bits is a word; any other length is dropped.
    if (!act && act_ff &&
        (cnt_ff == pcm_port_pkg::NARROW_BITS || cnt_ff == pcm_port_pkg::WIDE_BITS))
    begin
      if (chb_ff)
      begin
        nxt_wb.valid = 1'b1;
        nxt_wb.wide  = (cnt_ff == pcm_port_pkg::WIDE_BITS);
        nxt_wb.data  = sh_ff;
      end
      else
      begin
        nxt_wa.valid = 1'b1;
        nxt_wa.wide  = (cnt_ff == pcm_port_pkg::WIDE_BITS);
        nxt_wa.data  = sh_ff;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sh_ff  <= '0;
      tx_ff  <= '0;
      cnt_ff <= '0;
      chb_ff <= 1'b0;
      act_ff <= 1'b0;
      oe_ff  <= 1'b0;
      wa_ff  <= '0;
      wb_ff  <= '0;
    end
    else
    begin
      sh_ff  <= nxt_sh;
      tx_ff  <= nxt_tx;
      cnt_ff <= nxt_cnt;
      chb_ff <= nxt_chb;
      act_ff <= act;
      oe_ff  <= nxt_oe;
      wa_ff  <= nxt_wa;
      wb_ff  <= nxt_wb;
    end
  end

  assign word_a_o  = wa_ff;
  assign word_b_o  = wb_ff;
  assign dout_o    = oe_ff ? tx_ff[pcm_port_pkg::WORD_W-1] : 1'b0;
  assign dout_oe_o = oe_ff;
endmodule : pcm_lane

// -----------------------------------------------------------------------------
// Top level.
// -----------------------------------------------------------------------------
module pcm_serial_port
(
  input  wire logic                            clock_i,
  input  wire logic                            arst_n_i,
  input  wire logic                            power_down_n_i,
  input  wire logic                            strobed_serial_mode_i,
  input  wire logic                            linear_format_i,
  input  wire logic                            bit_clock_i,
  input  wire logic                            rx_side_strobe_a_i,
  input  wire logic                            rx_side_strobe_b_i,
  input  wire logic                            tx_side_strobe_a_i,
  input  wire logic                            tx_side_strobe_b_i,
  input  wire logic                            rx_in_i,
  input  wire logic                            tx_in_i,
  input  wire logic [pcm_port_pkg::WORD_W-1:0] send_out_a_i,
  input  wire logic [pcm_port_pkg::WORD_W-1:0] send_out_b_i,
  input  wire logic [pcm_port_pkg::WORD_W-1:0] rx_out_a_i,
  input  wire logic [pcm_port_pkg::WORD_W-1:0] rx_out_b_i,
  output pcm_port_pkg::pcm_word_t              ref_a_o,
  output pcm_port_pkg::pcm_word_t              ref_b_o,
  output pcm_port_pkg::pcm_word_t              send_a_o,
  output pcm_port_pkg::pcm_word_t              send_b_o,
  output logic                                 linear_o,
  output logic [1:0]                           rx_bus_mode_o,
  output logic [1:0]                           tx_bus_mode_o,
  output logic                                 send_out_o,
  output logic                                 send_out_oe_o,
  output logic                                 rx_out_o,
  output logic                                 rx_out_oe_o,
  output logic                                 standby_o
);
  logic                       rst_n;
  logic [6:0]                 s1_ff, s2_ff;
  logic                       bclk_ff;
  logic                       mode_ff;
  logic                       lin_ff;
  logic [1:0]                 rxm_ff, txm_ff;
  logic [1:0]                 nxt_rxm, nxt_txm;
  logic                       bclk_rise, bclk_fall;
  pcm_port_pkg::strobe_pair_t rx_stb, tx_stb;

  // Power-down acts as a reset; it is combined with the chip reset, not clocked.
  assign rst_n     = arst_n_i && power_down_n_i;
  assign standby_o = ~power_down_n_i;

  // Two-stage synchronisers; the first stage feeds only the second.
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      bclk_ff <= 1'b0;
    end
    else
    begin
      s1_ff   <= {bit_clock_i, rx_side_strobe_a_i, rx_side_strobe_b_i,
                  tx_side_strobe_a_i, tx_side_strobe_b_i, rx_in_i, tx_in_i};
      s2_ff   <= s1_ff;
      bclk_ff <= s2_ff[6];
    end
  end

  // 4096 kbit/s gives about five master clocks per bit, enough to see both edges.
  assign bclk_rise = s2_ff[6] && !bclk_ff;
  assign bclk_fall = !s2_ff[6] && bclk_ff;
  assign rx_stb    = '{a: s2_ff[5], b: s2_ff[4]};
  assign tx_stb    = '{a: s2_ff[3], b: s2_ff[2]};

  // In framed mode the strobe pins are decoded as static sub-mode selects.
  always_comb
  begin
    nxt_rxm = rxm_ff;
    nxt_txm = txm_ff;
    if (!strobed_serial_mode_i)
    begin
      nxt_rxm = {rx_stb.a, rx_stb.b};
      nxt_txm = {tx_stb.a, tx_stb.b};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= 1'b0;
      lin_ff  <= 1'b0;
      rxm_ff  <= '0;
      txm_ff  <= '0;
    end
    else
    begin
      mode_ff <= strobed_serial_mode_i;
      lin_ff  <= linear_format_i;
      rxm_ff  <= nxt_rxm;
      txm_ff  <= nxt_txm;
    end
  end

  assign linear_o      = lin_ff;
  assign rx_bus_mode_o = rxm_ff;
  assign tx_bus_mode_o = txm_ff;

  // Receive-in / send-out lane, strobed by the receive-side pair.
  pcm_lane u_rx_lane
  (
    .clock_i     (clock_i),
    .arst_n_i    (rst_n),
    .bclk_rise_i (bclk_rise),
    .bclk_fall_i (bclk_fall),
    .strobed_i   (mode_ff),
    .strobe_i    (rx_stb),
    .din_i       (s2_ff[1]),
    .out_a_i     (send_out_a_i),
    .out_b_i     (send_out_b_i),
    .word_a_o    (ref_a_o),
    .word_b_o    (ref_b_o),
    .dout_o      (send_out_o),
    .dout_oe_o   (send_out_oe_o)
  );

  // Send-in / receive-out lane, strobed by the send-side pair.
  pcm_lane u_tx_lane
  (
    .clock_i     (clock_i),
    .arst_n_i    (rst_n),
    .bclk_rise_i (bclk_rise),
    .bclk_fall_i (bclk_fall),
    .strobed_i   (mode_ff),
    .strobe_i    (tx_stb),
    .din_i       (s2_ff[0]),
    .out_a_i     (rx_out_a_i),
    .out_b_i     (rx_out_b_i),
    .word_a_o    (send_a_o),
    .word_b_o    (send_b_o),
    .dout_o      (rx_out_o),
    .dout_oe_o   (rx_out_oe_o)
  );
endmodule : pcm_serial_port

/* tb.sv */
// Self-checking bench for the serial PCM port with a framer model.
// Assumes a 20 MHz master clock; inputs change on its falling edge.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, arst_n_i = 0, power_down_n_i = 1, strobed_serial_mode_i = 1;
  logic linear_format_i = 0, bclk, send_out_o, send_out_oe_o, rx_out_o, rx_out_oe_o;
  logic standby_o, linear_o;
  logic [15:0] ow [4];
  logic [31:0] r;
  logic [3:0] stb;
  logic [1:0] din, rx_bus_mode_o, tx_bus_mode_o;
  pcm_port_pkg::pcm_word_t ref_a_o, ref_b_o, send_a_o, send_b_o;
  int n_errors = 0, checks_done = 0, seed = 32'h3377;

  pcm_framer pcm_framer_inst (.clock_i, .dout_i({rx_out_o, send_out_o}), .bclk_o(bclk),
    .stb_o(stb), .din_o(din));
  pcm_serial_port pcm_serial_port_inst (.clock_i, .arst_n_i, .power_down_n_i,
    .strobed_serial_mode_i, .linear_format_i, .bit_clock_i(bclk), .rx_side_strobe_a_i(stb[0]),
    .rx_side_strobe_b_i(stb[1]), .tx_side_strobe_a_i(stb[2]), .tx_side_strobe_b_i(stb[3]),
    .rx_in_i(din[0]), .tx_in_i(din[1]), .send_out_a_i(ow[0]), .send_out_b_i(ow[1]),
    .rx_out_a_i(ow[2]), .rx_out_b_i(ow[3]), .ref_a_o, .ref_b_o, .send_a_o, .send_b_o,
    .linear_o, .rx_bus_mode_o, .tx_bus_mode_o, .send_out_o, .send_out_oe_o, .rx_out_o,
    .rx_out_oe_o, .standby_o);

  // Master clock, 50 ns period.
  initial forever #25 clock_i = ~clock_i;

  task automatic chk(input logic [18:0] seen, input logic [18:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // An 8-bit burst carries only a byte, so the high byte is zeroed for the compare.
  function automatic logic [15:0] keep(input int nb, input logic [15:0] w);
    return (nb == 16) ? w : {8'h00, w[7:0]};
  endfunction : keep

  function automatic pcm_port_pkg::pcm_word_t pick(input int k);
    return (k == 0) ? ref_a_o : (k == 1) ? ref_b_o : (k == 2) ? send_a_o : send_b_o;
  endfunction : pick

  // One burst in both directions, then the word seen on each side.
  task automatic xfer(input int l, input int ch, input int nb, input int half,
                      input logic [15:0] w);
    logic [15:0] got;
    pcm_port_pkg::pcm_word_t wd;
    int k;
    k = 2 * l + ch;
    wd = '0;
    pcm_framer_inst.send(l, ch, nb, half, w, got);
    repeat (8)
    begin
      @(posedge clock_i) #1;
      if (pick(k).valid === 1'b1) wd = pick(k);
    end
    if (nb == 9) chk(wd.valid, 0, "odd burst");
    else
    begin
      chk(wd, {1'b1, nb == 16, keep(nb, w)}, "word in");
      chk(keep(nb, got), keep(nb, nb == 16 ? ow[k] : ow[k] >> 8), "word out");
    end
  endtask : xfer

  // Main sequence.
  initial
  begin
    for (int i = 0; i < 4; i++) ow[i] = 16'($random(seed));
    repeat (20) @(negedge clock_i);
    arst_n_i = 1;
    repeat (2) @(negedge clock_i);
    power_down_n_i = 0;
    @(negedge clock_i);
    chk({standby_o, send_out_oe_o, ref_a_o[16:0]}, 19'h40000, "power down");
    power_down_n_i = 1;
    $display("test power down done");
    xfer(0, 0, 16, 6, 16'h8001);
    xfer(0, 1, 8, 6, 16'h00a5);
    xfer(1, 0, 8, 3, 16'h005a);
    xfer(1, 1, 16, 78, 16'hc3e1);
    xfer(0, 0, 9, 6, 16'h01ff);
    $display("test corners done");
    for (int n = 0; n < 12; n++)
    begin
      @(negedge clock_i);
      r = $random(seed);
      ow[r[1:0]] = r[31:16];
      linear_format_i = r[4];
      xfer(r[2], r[3], r[5] ? 16 : 8, 5 + r[8:6], r[31:16] ^ 16'h5a5a);
      chk(linear_o, r[4], "format");
    end
    $display("test random done");
    @(negedge clock_i);
    strobed_serial_mode_i = 0;
    for (int i = 0; i < 4; i++)
    begin
      pcm_framer_inst.stb_o = {i[1:0], i[1:0]};
      repeat (6) @(negedge clock_i);
      chk({rx_bus_mode_o, tx_bus_mode_o}, {i[0], i[1], i[0], i[1]}, "bus mode");
    end
    $display("test framed done");
    wrap_up();
  end

  // Watchdog: 17 bursts, each at worst one frame wait plus one slow burst, need under 50000.
  initial
  begin
    repeat (80000) @(posedge clock_i);
    n_errors++;
    wrap_up();
  end
endmodule : tb
